// >>> asp_host_model.sv
// Purpose: far-end audio processor driving one serial link in slave-port setups
// Assumes: 64 ns bit clock, standard framing, 32-bit slots
// Notes: bit clock stands still between bursts; data line is inverted once as each burst ends
`default_nettype none

module asp_host_model (
   // link pins from the far end
   output logic bclk,
   output logic ws,
   output logic sd
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      bclk = 1'b0;
      ws = 1'b1;
      sd = 1'b0;
   end

   // slots are passed msb-justified, so any sample width is cut by the receiver
   task automatic burst(input int n, input logic [31:0] l, input logic [31:0] r);
      logic [63:0] fr;
      fr = {l, r};
      #13;
      for (int k = 0; k < n * 64; k++) begin
         ws = (k % 64) >= 32;
         sd = fr[(64 - k % 64) % 64];
         #16 bclk = 1'b1;
         #32 bclk = 1'b0;
         #16;
      end
      // released line must not look like held data
      sd = ~sd;
   endtask : burst
endmodule : asp_host_model

`default_nettype wire

// >>> asp_pkg.sv
// Purpose: shared constants and types for the audio serial port block
// Assumes: 25 MHz core clock, 8-bit register port at byte offsets
// Notes: all registers reset to zero
`default_nettype none

package asp_pkg;
   // register offsets
   localparam logic [7:0] FEED1_OFS = 8'hC2;
   localparam logic [7:0] FEED2_OFS = 8'hC3;
   localparam logic [7:0] FMT1_OFS = 8'hC9;
   localparam logic [7:0] LNK1_OFS = 8'hCA;
   localparam logic [7:0] FMT2_OFS = 8'hCB;
   localparam logic [7:0] LNK2_OFS = 8'hCC;
   localparam logic [7:0] BLK_PWR_OFS = 8'hD1;
   localparam logic [7:0] CH_PWR_OFS = 8'hD2;

   // format and rate register fields
   localparam int WIDTH_LSB = 0;
   localparam int DIV_LSB = 2;
   localparam int SCALE_LSB = 5;
   localparam int FAMILY_BIT = 7;
   // link control register fields
   localparam int FRAMING_LSB = 0;
   localparam int RX_BIT = 2;
   localparam int SWAP_BIT = 3;
   localparam int FRAME_SYNC_INVERT_BIT = 4;
   localparam int BCINV_BIT = 5;
   localparam int ROLE_BIT = 6;
   localparam int TX_BIT = 7;
   // block power register fields, then the feed select field
   localparam int LINE_IN_BIT = 0;
   localparam int SERIAL_BIT = 1;
   localparam int REF_BIT = 2;
   localparam int IN_ALL_BIT = 3;
   localparam int OUT_ALL_BIT = 4;
   localparam int STANDBY_BIT = 5;
   localparam int FEED_LSB = 0;

   // settings word carried to the link domain
   localparam int CFG_W = 11;
   localparam int CFG_LNK_LSB = 2;
   localparam int CFG_ACTIVE_BIT = 10;

   typedef enum logic [1:0] {
      FRAME_STD = 2'h0, FRAME_LEFT = 2'h1, FRAME_RIGHT = 2'h2, FRAME_RSVD = 2'h3
   } asp_framing_t;
   typedef enum logic [1:0] {
      WIDTH_16 = 2'h0, WIDTH_20 = 2'h1, WIDTH_24 = 2'h2, WIDTH_RSVD = 2'h3
   } asp_width_t;
   typedef enum logic [1:0] {
      SCALE_ONE = 2'h0, SCALE_TWO = 2'h1, SCALE_RSVD2 = 2'h2, SCALE_RSVD3 = 2'h3
   } asp_scale_t;
   typedef enum logic [1:0] {
      FEED_SER_ONE = 2'h0, FEED_SER_TWO = 2'h1, FEED_ADC0 = 2'h2, FEED_ADC1 = 2'h3
   } asp_feed_t;

   // timing
   localparam int CLK_HZ = 25_000_000;
   localparam int FAMILY_48_HZ = 48_000;
   localparam int FAMILY_44_HZ = 44_100;
   localparam int BCLK_PER_FRAME = 64;
   localparam int SLOT_BITS = 32;
   localparam int HALF_48_RAW = CLK_HZ / (2 * FAMILY_48_HZ * BCLK_PER_FRAME);
   localparam int HALF_44_RAW = CLK_HZ / (2 * FAMILY_44_HZ * BCLK_PER_FRAME);
   localparam logic [7:0] HALF_48_CYC = 8'((HALF_48_RAW < 1) ? 1 : HALF_48_RAW);
   localparam logic [7:0] HALF_44_CYC = 8'((HALF_44_RAW < 1) ? 1 : HALF_44_RAW);
   localparam int SAMPLE_W = 24;
   localparam int PAIR_W = 48;

   function automatic logic [4:0] sample_bits(input logic [1:0] code);
      case (code)
         WIDTH_16: sample_bits = 5'h10;
         WIDTH_20: sample_bits = 5'h14;
         default: sample_bits = 5'h18;
      endcase
   endfunction : sample_bits

   function automatic logic [23:0] width_mask(input logic [4:0] bits);
      width_mask = 24'((25'h0000001 << bits) - 25'h0000001);
   endfunction : width_mask
endpackage : asp_pkg

`default_nettype wire

// >>> asp_top.sv
// Purpose: two serial audio ports with register control and audio power gating
// Assumes: link clock is the bit-clock pin level, also when this end drives it
// Notes: register port is the controller's byte-wide address space
`default_nettype none

module asp_fifo #(
   parameter int WIDTH = 48,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } asp_fifo_state_t;
   asp_fifo_state_t s, nx;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push, pop;

   assign in_ready = (s.cnt != (AW + 1)'(DEPTH));
   assign out_valid = (s.cnt != '0);
   assign out_data = mem[s.rp];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      nx = s;
      if (push) begin
         nx.wp = (s.wp == AW'(DEPTH - 1)) ? '0 : s.wp + AW'(1);
      end
      if (pop) begin
         nx.rp = (s.rp == AW'(DEPTH - 1)) ? '0 : s.rp + AW'(1);
      end
      nx.cnt = s.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else if (ce) begin
         s <= nx;
      end
   end

   always_ff @(posedge clk) begin
      if (ce && push) begin
         mem[s.wp] <= in_data;
      end
   end
endmodule : asp_fifo

module asp_link (
   // link clock and reset
   input wire logic link_clk,
   input wire logic rst_n,
   // settings from the core domain
   input wire logic [asp_pkg::CFG_W-1:0] cfg_in,
   // serial pins
   input wire logic sdin,
   input wire logic wclk_i,
   output logic wclk_o,
   output logic sdout_o,
   // pairs to and from the core domain
   output logic [asp_pkg::PAIR_W-1:0] rx_pair,
   output logic rx_tgl,
   input wire logic [asp_pkg::PAIR_W-1:0] tx_hold,
   input wire logic tx_tgl
);
   typedef struct packed {
      logic [asp_pkg::CFG_W-1:0] cfg_s1;
      logic [asp_pkg::CFG_W-1:0] cfg_s2;
      logic [2:0] txt;
      logic ws_q;
      logic left_q;
      logic ws_gen;
      logic [5:0] cnt;
      logic [6:0] len;
      logic [23:0] shreg;
      logic [23:0] left_hold;
      logic [47:0] rx_pair;
      logic [47:0] tx_pend;
      logic [47:0] tx_cur;
      logic rx_tgl;
      logic tx_bit;
   } asp_link_state_t;
   typedef struct packed {
      logic sd;
      logic ws;
      logic tx;
   } asp_link_neg_t;
   asp_link_state_t s, nx;
   asp_link_neg_t ng;
   logic [asp_pkg::CFG_W-1:0] cfg;

   assign cfg = s.cfg_s2;
   assign wclk_o = s.ws_gen ^ cfg[asp_pkg::CFG_LNK_LSB + asp_pkg::FRAME_SYNC_INVERT_BIT];
   assign sdout_o = cfg[asp_pkg::CFG_LNK_LSB + asp_pkg::BCINV_BIT] ? s.tx_bit : ng.tx;
   assign rx_pair = s.rx_pair;
   assign rx_tgl = s.rx_tgl;

   always_comb begin
      logic [4:0] w;
      logic [1:0] fmt;
      logic sd, wsp, ws_now, left_now, edge_seen, nleft, take, rx_take, role, active;
      logic [5:0] c;
      logic [6:0] len_eff, nc, off, idx, w7;
      logic [23:0] base, tx_word;
      logic [47:0] cur;
      sd = 1'b0;
      wsp = 1'b0;
      ws_now = 1'b0;
      left_now = 1'b0;
      edge_seen = 1'b0;
      nleft = 1'b0;
      take = 1'b0;
      rx_take = 1'b0;
      c = 6'h00;
      len_eff = 7'h00;
      nc = 7'h00;
      off = 7'h00;
      idx = 7'h00;
      base = 24'h000000;
      tx_word = 24'h000000;
      cur = 48'h000000000000;
      nx = s;
      w = asp_pkg::sample_bits(cfg[1:0]);
      w7 = {2'b00, w};
      fmt = cfg[asp_pkg::CFG_LNK_LSB + asp_pkg::FRAMING_LSB +: 2];
      role = cfg[asp_pkg::CFG_LNK_LSB + asp_pkg::ROLE_BIT];
      active = cfg[asp_pkg::CFG_ACTIVE_BIT];
      nx.cfg_s1 = cfg_in;
      nx.cfg_s2 = s.cfg_s1;
      nx.txt = {s.txt[1:0], tx_tgl};
      sd = cfg[asp_pkg::CFG_LNK_LSB + asp_pkg::BCINV_BIT] ? ng.sd : sdin;
      wsp = cfg[asp_pkg::CFG_LNK_LSB + asp_pkg::BCINV_BIT] ? ng.ws : wclk_i;
      ws_now = role ? s.ws_gen : (wsp ^ cfg[asp_pkg::CFG_LNK_LSB + asp_pkg::FRAME_SYNC_INVERT_BIT]);
      left_now = (fmt == asp_pkg::FRAME_STD) ? !ws_now : ws_now;
      edge_seen = (ws_now != s.ws_q);
      nx.ws_q = ws_now;
      nx.left_q = left_now;
      c = edge_seen ? 6'h00 : ((s.cnt == 6'h3F) ? s.cnt : s.cnt + 6'h01);
      nx.cnt = c;
      off = (fmt == asp_pkg::FRAME_STD) ? 7'h01 : 7'h00;
      if (s.txt[2] != s.txt[1]) begin
         nx.tx_pend = tx_hold;
      end
      if (role && c == 6'(asp_pkg::SLOT_BITS - 1)) begin
         nx.ws_gen = !s.ws_gen;
      end
      if (edge_seen) begin
         nx.len = {1'b0, s.cnt} + 7'h01;
         if (s.left_q) begin
            nx.left_hold = s.shreg & asp_pkg::width_mask(w);
         end else if (cfg[asp_pkg::CFG_LNK_LSB + asp_pkg::RX_BIT] && active) begin
            nx.rx_pair = {s.left_hold, s.shreg & asp_pkg::width_mask(w)};
            nx.rx_tgl = !s.rx_tgl;
         end
      end
      rx_take = (fmt == asp_pkg::FRAME_RIGHT) || ({1'b0, c} >= off && {1'b0, c} < off + w7);
      base = edge_seen ? 24'h000000 : s.shreg;
      nx.shreg = rx_take ? {base[22:0], sd} : base;
      // predict the next bit position for transmit
      len_eff = role ? 7'(asp_pkg::SLOT_BITS) : nx.len;
      nc = {1'b0, c} + 7'h01;
      nleft = left_now;
      if (nc >= len_eff) begin
         nc = 7'h00;
         nleft = !left_now;
      end
      cur = (nc == 7'h00 && nleft) ? s.tx_pend : s.tx_cur;
      nx.tx_cur = cur;
      tx_word = (nleft ^ cfg[asp_pkg::CFG_LNK_LSB + asp_pkg::SWAP_BIT]) ? cur[47:24] : cur[23:0];
      if (fmt == asp_pkg::FRAME_RIGHT) begin
         take = (nc + w7 >= len_eff);
         idx = len_eff - 7'h01 - nc;
      end else begin
         take = (nc >= off) && (nc < off + w7);
         idx = off + w7 - 7'h01 - nc;
      end
      nx.tx_bit = cfg[asp_pkg::CFG_LNK_LSB + asp_pkg::TX_BIT] && active && take
         && tx_word[idx[4:0]];
   end

   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= nx;
      end
   end

   // the other edge of the bit clock, used for inversion
   always_ff @(negedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         ng <= '0;
      end else begin
         ng <= '{sd: sdin, ws: wclk_i, tx: s.tx_bit};
      end
   end
endmodule : asp_link

module asp_top #(
   parameter int FIFO_DEPTH = 8
) (
   // clock, reset, enable
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // serial link pins per port
   input wire logic [1:0] link_clk,
   input wire logic [1:0] sdin,
   input wire logic [1:0] wclk_i,
   output logic [1:0] wclk_o,
   output logic [1:0] wclk_oe_n,
   output logic [1:0] bclk_o,
   output logic [1:0] bclk_oe_n,
   output logic [1:0] sdout_o,
   output logic [1:0] sdout_oe_n,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // converter samples, left in the upper half
   input wire logic [1:0] adc_valid,
   input wire logic [1:0][asp_pkg::PAIR_W-1:0] adc_data,
   // received pairs
   output logic [1:0] rx_valid,
   input wire logic [1:0] rx_ready,
   output logic [1:0][asp_pkg::PAIR_W-1:0] rx_data,
   output logic [1:0] rx_drop,
   // power controls
   output logic line_input_stage_off,
   output logic serial_path_off,
   output logic reference_off,
   output logic all_converters_in_off,
   output logic all_converters_out_off,
   output logic standby_on,
   output logic [7:0] conv_half_off
);
   typedef struct packed {
      logic [1:0][7:0] feed;
      logic [1:0][7:0] fmt;
      logic [1:0][7:0] lnk;
      logic [7:0] blk_pwr;
      logic [7:0] ch_pwr;
      logic [7:0] rdata;
      logic [1:0][2:0] rxt;
      logic [1:0][47:0] rx_last;
      logic [1:0][47:0] tx_hold;
      logic [1:0] tx_tgl;
      logic [1:0] bclk;
      logic [1:0] push;
      logic [1:0][7:0] div_cnt;
   } asp_core_state_t;
   asp_core_state_t s, nx;
   logic active;
   logic [1:0] fifo_ready;
   logic [1:0] link_rx_tgl;
   logic [1:0][asp_pkg::PAIR_W-1:0] link_rx_pair;

   assign line_input_stage_off = s.blk_pwr[asp_pkg::LINE_IN_BIT];
   assign serial_path_off = s.blk_pwr[asp_pkg::SERIAL_BIT];
   assign reference_off = s.blk_pwr[asp_pkg::REF_BIT];
   assign all_converters_in_off = s.blk_pwr[asp_pkg::IN_ALL_BIT];
   assign all_converters_out_off = s.blk_pwr[asp_pkg::OUT_ALL_BIT];
   assign standby_on = s.blk_pwr[asp_pkg::STANDBY_BIT];
   // per-half gates, also forced by the gross bits
   assign conv_half_off = s.ch_pwr | {{4{all_converters_in_off}}, {4{all_converters_out_off}}}
      | {8{standby_on}};
   // ports stop while the serial path is off
   assign active = !serial_path_off && !standby_on;
   assign reg_rdata = s.rdata;
   assign rx_drop = s.push & ~fifo_ready;

   for (genvar g = 0; g < 2; g++) begin : g_port
      assign bclk_oe_n[g] = !s.lnk[g][asp_pkg::ROLE_BIT];
      assign wclk_oe_n[g] = !s.lnk[g][asp_pkg::ROLE_BIT];
      assign bclk_o[g] = s.bclk[g] ^ s.lnk[g][asp_pkg::BCINV_BIT];
      assign sdout_oe_n[g] = !(s.lnk[g][asp_pkg::TX_BIT] && active);

      asp_link u_link (
         .link_clk(link_clk[g]),
         .rst_n(rst_n),
         .cfg_in({active, s.lnk[g], s.fmt[g][asp_pkg::WIDTH_LSB +: 2]}),
         .sdin(sdin[g]),
         .wclk_i(wclk_i[g]),
         .wclk_o(wclk_o[g]),
         .sdout_o(sdout_o[g]),
         .rx_pair(link_rx_pair[g]),
         .rx_tgl(link_rx_tgl[g]),
         .tx_hold(s.tx_hold[g]),
         .tx_tgl(s.tx_tgl[g])
      );

      asp_fifo #(.WIDTH(asp_pkg::PAIR_W), .DEPTH(FIFO_DEPTH)) u_fifo (
         .clk(clk),
         .rst_n(rst_n),
         .ce(ce),
         .in_valid(s.push[g]),
         .in_ready(fifo_ready[g]),
         .in_data(s.rx_last[g]),
         .out_valid(rx_valid[g]),
         .out_ready(rx_ready[g]),
         .out_data(rx_data[g])
      );
   end

   always_comb begin
      logic [1:0] rx_ev;
      logic ev;
      logic [47:0] src;
      logic [10:0] half;
      nx = s;
      rx_ev = 2'b00;
      ev = 1'b0;
      src = '0;
      half = '0;
      if (reg_wr) begin
         case (reg_addr)
            asp_pkg::FEED1_OFS: nx.feed[0] = reg_wdata;
            asp_pkg::FEED2_OFS: nx.feed[1] = reg_wdata;
            asp_pkg::FMT1_OFS: nx.fmt[0] = reg_wdata;
            asp_pkg::LNK1_OFS: nx.lnk[0] = reg_wdata;
            asp_pkg::FMT2_OFS: nx.fmt[1] = reg_wdata;
            asp_pkg::LNK2_OFS: nx.lnk[1] = reg_wdata;
            asp_pkg::BLK_PWR_OFS: nx.blk_pwr = reg_wdata;
            asp_pkg::CH_PWR_OFS: nx.ch_pwr = reg_wdata;
            default: ;
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            asp_pkg::FEED1_OFS: nx.rdata = s.feed[0];
            asp_pkg::FEED2_OFS: nx.rdata = s.feed[1];
            asp_pkg::FMT1_OFS: nx.rdata = s.fmt[0];
            asp_pkg::LNK1_OFS: nx.rdata = s.lnk[0];
            asp_pkg::FMT2_OFS: nx.rdata = s.fmt[1];
            asp_pkg::LNK2_OFS: nx.rdata = s.lnk[1];
            asp_pkg::BLK_PWR_OFS: nx.rdata = s.blk_pwr;
            asp_pkg::CH_PWR_OFS: nx.rdata = s.ch_pwr;
            default: nx.rdata = 8'h00;
         endcase
      end
      // pair held a whole frame, so the toggle alone marks it stable
      for (int i = 0; i < 2; i++) begin
         nx.rxt[i] = {s.rxt[i][1:0], link_rx_tgl[i]};
         rx_ev[i] = (s.rxt[i][2] != s.rxt[i][1]);
         nx.push[i] = 1'b0;
         if (rx_ev[i]) begin
            nx.rx_last[i] = link_rx_pair[i];
            nx.push[i] = s.lnk[i][asp_pkg::RX_BIT];
         end
      end
      for (int i = 0; i < 2; i++) begin
         case (s.feed[i][asp_pkg::FEED_LSB +: 2])
            asp_pkg::FEED_SER_ONE: begin
               ev = rx_ev[0];
               src = link_rx_pair[0];
            end
            asp_pkg::FEED_SER_TWO: begin
               ev = rx_ev[1];
               src = link_rx_pair[1];
            end
            asp_pkg::FEED_ADC0: begin
               ev = adc_valid[0];
               src = adc_data[0];
            end
            default: begin
               ev = adc_valid[1];
               src = adc_data[1];
            end
         endcase
         if (ev) begin
            nx.tx_hold[i] = src;
            nx.tx_tgl[i] = !s.tx_tgl[i];
         end
         half = {3'b000, s.fmt[i][asp_pkg::FAMILY_BIT] ? asp_pkg::HALF_44_CYC
            : asp_pkg::HALF_48_CYC};
         half = 11'(half * ({8'h00, s.fmt[i][asp_pkg::DIV_LSB +: 3]} + 11'h001));
         if (s.fmt[i][asp_pkg::SCALE_LSB +: 2] == asp_pkg::SCALE_TWO) begin
            half = half >> 1;
         end
         if (half == 11'h000) begin
            half = 11'h001;
         end
         if (s.lnk[i][asp_pkg::ROLE_BIT] && active) begin
            if (s.div_cnt[i] == 8'h00) begin
               nx.div_cnt[i] = 8'(half - 11'h001);
               nx.bclk[i] = !s.bclk[i];
            end else begin
               nx.div_cnt[i] = s.div_cnt[i] - 8'h01;
            end
         end else begin
            nx.div_cnt[i] = 8'h00;
            nx.bclk[i] = 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else if (ce) begin
         s <= nx;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   port_isolate_a: assert property (
      (ce && reg_wr && reg_addr == asp_pkg::FMT2_OFS) |=> s.fmt[0] == $past(s.fmt[0]))
      else $error("port one format changed by port two write");
   rx_gate_a: assert property (
      (ce && s.push[0]) |-> $past(s.lnk[0][asp_pkg::RX_BIT]))
      else $error("pair pushed with receive disabled");
   tx_release_a: assert property (
      !s.lnk[0][asp_pkg::TX_BIT] |-> sdout_oe_n[0])
      else $error("data pin driven with transmit disabled");
   slave_pins_a: assert property (
      (ce && reg_wr && reg_addr == asp_pkg::LNK2_OFS && !reg_wdata[asp_pkg::ROLE_BIT])
      |=> (bclk_oe_n[1] && wclk_oe_n[1]) ##1 (s.bclk[1] == 1'b0))
      else $error("slave port drives clocks");
   block_power_a: assert property (
      (ce && reg_wr && reg_addr == asp_pkg::BLK_PWR_OFS) |=>
      reference_off == $past(reg_wdata[asp_pkg::REF_BIT])
      && serial_path_off == $past(reg_wdata[asp_pkg::SERIAL_BIT]))
      else $error("block power bit not applied");
   standby_all_a: assert property (
      standby_on |-> (conv_half_off == 8'hFF) && (sdout_oe_n == 2'b11))
      else $error("standby leaves a block powered");
   half_off_a: assert property (
      (ce && reg_wr && reg_addr == asp_pkg::CH_PWR_OFS) |=>
      ($past(reg_wdata) & ~conv_half_off) == 8'h00)
      else $error("written half still powered");
   feed_adc_a: assert property (
      (ce && adc_valid[1] && s.feed[0][1:0] == asp_pkg::FEED_ADC1)
      |=> s.tx_hold[0] == $past(adc_data[1]) && s.tx_tgl[0] != $past(s.tx_tgl[0]))
      else $error("converter sample not taken for port one");
   bclk_rate_a: assert property (
      (ce && s.lnk[0][asp_pkg::ROLE_BIT] && active && s.div_cnt[0] != 8'h00)
      |=> s.bclk[0] == $past(s.bclk[0]) || !ce)
      else $error("bit clock toggled before count ran out");

   push_seen_c: cover property (ce && s.push[0] && fifo_ready[0]);
   fifo_full_c: cover property (ce && s.push[1] && !fifo_ready[1]);
   tx_update_c: cover property (ce && s.tx_tgl[1] != $past(s.tx_tgl[1]));
   master_clk_c: cover property (ce && s.bclk[0] && !$past(s.bclk[0]));
endmodule : asp_top

`default_nettype wire

// >>> test_audio_serial_port_config.sv
// Purpose: register, power and link checks of the audio serial port block
// Assumes: 25 MHz core clock, slave ports fed by the host model
// Notes: master loops the driven bit clock back as the link clock
`default_nettype none

module test_audio_serial_port_config;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk = 0, rst_n = 0, ce = 1, reg_wr = 0, reg_rd = 0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
   logic [1:0] rx_ready = 2'h3;
   logic [1:0] adc_valid = 2'h0;
   logic [1:0][47:0] adc_data = '0;
   time t0;
   logic [47:0] rx_last = 48'h0;
   wire [1:0] link_clk, wclk_i, sdin, wclk_o, wclk_oe_n, bclk_o, bclk_oe_n;
   wire [1:0] sdout_oe_n, rx_valid, pb, pw, ps, sdout_o;
   wire [1:0][47:0] rx_data;
   wire [7:0] reg_rdata, conv_half_off;
   wire [5:0] pwr;
   int error_cnt = 0, total_checks = 0, rx_cnt = 0, n0;
   localparam logic [7:0] OFS [8] = '{8'hC2, 8'hC3, 8'hC9, 8'hCA, 8'hCB, 8'hCC, 8'hD1, 8'hD2};

   for (genvar i = 0; i < 2; i++) begin : g_pin
      assign link_clk[i] = bclk_oe_n[i] ? pb[i] : bclk_o[i];
      assign wclk_i[i] = wclk_oe_n[i] ? pw[i] : wclk_o[i];
      // data loops back while this end transmits
      assign sdin[i] = sdout_oe_n[i] ? ps[i] : sdout_o[i];
      asp_host_model u_host (.bclk(pb[i]), .ws(pw[i]), .sd(ps[i]));
   end

   asp_top u_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .link_clk(link_clk), .sdin(sdin),
      .wclk_i(wclk_i), .wclk_o(wclk_o), .wclk_oe_n(wclk_oe_n), .bclk_o(bclk_o),
      .bclk_oe_n(bclk_oe_n), .sdout_o(sdout_o), .sdout_oe_n(sdout_oe_n), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .adc_valid(adc_valid), .adc_data(adc_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
      .rx_data(rx_data), .rx_drop(), .line_input_stage_off(pwr[0]),
      .serial_path_off(pwr[1]), .reference_off(pwr[2]), .all_converters_in_off(pwr[3]),
      .all_converters_out_off(pwr[4]), .standby_on(pwr[5]), .conv_half_off(conv_half_off));

   always #20 clk = ~clk;

   // ready is held high, so every valid cycle is a pop
   always @(posedge clk) begin
      if (rx_valid[0] === 1'b1) begin
         rx_cnt++;
         rx_last <= rx_data[0];
      end
   end

   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk(reg_rdata, exp);
   endtask : rdc

   task automatic tally_and_finish;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : tally_and_finish

   initial begin
      #2_000_000;
      error_cnt++;
      tally_and_finish();
   end

   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      foreach (OFS[i]) rdc(OFS[i], 8'h00);
      foreach (OFS[i]) begin
         wr(OFS[i], OFS[i] ^ 8'h5A);
         rdc(OFS[i], OFS[i] ^ 8'h5A);
         wr(OFS[i], 8'h00);
      end
      // unmapped offset keeps nothing
      wr(8'hE0, 8'hFF);
      rdc(8'hE0, 8'h00);
      for (int i = 0; i < 6; i++) begin
         wr(8'hD1, 8'h01 << i);
         chk(pwr, 6'h01 << i);
         chk(conv_half_off, {{4{i == 3}}, {4{i == 4}}} | {8{i == 5}});
      end
      wr(8'hD1, 8'h00);
      wr(8'hD2, 8'hA5);
      chk(conv_half_off, 8'hA5);
      wr(8'hD2, 8'h00);
      wr(8'hCA, 8'h80);
      chk({sdout_oe_n[0], wclk_oe_n[0], bclk_oe_n[0]}, 3'b011);
      wr(8'hCA, 8'hC0);
      chk({sdout_oe_n[0], wclk_oe_n[0], bclk_oe_n[0]}, 3'b000);
      wr(8'hD1, 8'h02);
      chk(sdout_oe_n[0], 1'b1);
      wr(8'hD1, 8'h20);
      chk(sdout_oe_n[0], 1'b1);
      wr(8'hD1, 8'h00);
      wr(8'hCA, 8'h00);
      chk({sdout_oe_n[0], wclk_oe_n[0], bclk_oe_n[0]}, 3'b111);
      wr(8'hCC, 8'hC0);
      chk({sdout_oe_n[1], wclk_oe_n[1], bclk_oe_n[1]}, 3'b000);
      wr(8'hCC, 8'h00);
      // every legal width code, standard framing, slave
      for (int c = 0; c < 3; c++) begin
         wr(8'hC9, 8'(c));
         wr(8'hCA, 8'h04);
         g_pin[0].u_host.burst(3, 32'hF1E2D3C4, 32'h8796A5B4);
         repeat (20) @(posedge clk);
         chk(rx_last, {24'(32'hF1E2D3C4 >> (16 - 4 * c)),
            24'(32'h8796A5B4 >> (16 - 4 * c))});
         wr(8'hCA, 8'h00);
      end
      // loopback: master port one sends converter 1 pairs to itself
      wr(8'hC9, 8'h00);
      wr(8'hC2, 8'h03);
      wr(8'hCA, 8'hC4);
      @(posedge clk);
      adc_valid <= 2'b10;
      adc_data[1] <= 48'hFFA5C3_FF5A3C;
      @(posedge clk);
      adc_valid <= 2'b00;
      repeat (2048) @(posedge clk);
      chk(rx_last, 48'h00A5C3_005A3C);
      wr(8'hCA, 8'hCC);
      repeat (2048) @(posedge clk);
      chk(rx_last, 48'h005A3C_00A5C3);
      wr(8'hC9, 8'h84);
      @(posedge bclk_o[0]);
      t0 = $time;
      @(posedge bclk_o[0]);
      chk($time - t0, 4 * asp_pkg::HALF_44_CYC * 40);
      wr(8'hC9, 8'h24);
      @(posedge bclk_o[0]);
      t0 = $time;
      @(posedge bclk_o[0]);
      chk($time - t0, 2 * asp_pkg::HALF_48_CYC * 40);
      wr(8'hCA, 8'h00);
      n0 = rx_cnt;
      g_pin[0].u_host.burst(2, 32'h11223344, 32'h55667788);
      repeat (20) @(posedge clk);
      chk(rx_cnt, n0);
      tally_and_finish();
   end
endmodule : test_audio_serial_port_config

`default_nettype wire
